// File: rtl/pecint_pkg.sv
// package: register map, field positions and bus types for the pin edge change interrupt unit
package pecint_pkg;

    localparam int PIN_COUNT = 8;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // register word addresses
    localparam logic [ADDR_W-1:0] RISE_EN_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] FALL_EN_ADDR = 4'h1;
    localparam logic [ADDR_W-1:0] FLAGS_ADDR = 4'h2;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h3;
    localparam logic [ADDR_W-1:0] SLEEP_ADDR = 4'h4;

    // interrupt_control field positions
    localparam int CTRL_SUMMARY_BIT = 0;
    localparam int CTRL_MASTER_EN_BIT = 3;

    localparam logic [7:0] REG8_RESET = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECODEERROR = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } pecint_avm_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] readdata;
        logic readdatavalid;
        logic waitrequest;
        logic [1:0] response;
    } pecint_avm_rsp_t;

    typedef enum logic [1:0] {
        PECINT_IDLE = 2'b00,
        PECINT_ACK = 2'b01
    } pecint_bus_state_t;

endpackage : pecint_pkg

// File: rtl/pecint_top.sv
// pin edge change interrupt unit: edge detect, flags, summary, wake and register slave
// What this block does
// RULE_01: wake is requested from an enabled edge flag only while the master enable is set.
// RULE_02: an edge seen while asleep lands in the flag register before the wake request leaves the block.
// RULE_03: a rising enable bit of 1 arms detection of a low-to-high change on its pin.
// RULE_04: a falling enable bit of 1 arms detection of a high-to-low change, and both may be armed at once.
// RULE_05: an enable bit of 0 stops changes of that polarity from being recorded.
// RULE_06: a pin flag sets on an armed rising edge or an armed falling edge of that pin.
// RULE_07: a flag reads 0 when no armed change occurred or software wrote it to zero.
// RULE_08: the flag register is readable and writable by software and also set by hardware.
// RULE_09: an armed edge sets its pin flag and the module summary flag together.
// RULE_10: both enable registers and the flags clear to zero on every reset.
// RULE_11: the summary flag is the OR of all eight pin flags.
// RULE_12: with the master enable clear edges still set flags but no request is raised.
// RULE_13: an edge arriving during a clearing write leaves its flag set whatever is written.
// RULE_14: software clears only flags it has seen set, by masking, so new edges are not lost.
// RULE_15: each pin is sampled and compared with its previous sample to form one-cycle edge pulses.
// RULE_16: the request is master enable AND summary flag and holds until all flags are clear.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps

module pecint_top
    import pecint_pkg::*;
#(
    parameter int PINS = PIN_COUNT
)(
    input wire logic clk_i, // system clock, 25 MHz
    input wire logic srst_i, // synchronous reset, active high
    input wire logic [PINS-1:0] port_pin_input_i, // port pins, synchronous to clk_i
    input wire logic sleep_i, // processor is in sleep
    input wire pecint_pkg::pecint_avm_req_t avm_req_i, // avalon request
    output pecint_pkg::pecint_avm_rsp_t avm_rsp_o, // avalon answer
    output logic irq_o, // level interrupt request
    output logic wake_o // level wake request to the sleep controller
);
    import pecint_pkg::*;

    // elaboration check: the register layout is one byte per register
    if (PINS != 8)
    begin : g_pins_check
        $error("pecint_top: PINS must be 8, the register layout is one byte");
    end

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] rising_edge_enable_reg;
    logic [7:0] falling_edge_enable_reg;
    logic [7:0] pin_change_flags_reg;
    logic [7:0] pin_change_flags_next;
    logic change_irq_master_enable_reg;
    logic [7:0] pin_prev_reg;
    logic [7:0] rise_pulse;
    logic [7:0] fall_pulse;
    logic [7:0] edge_hit;
    logic change_summary_flag;
    logic irq_reg;
    logic wake_reg;
    pecint_bus_state_t bus_state_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [1:0] resp_reg;
    logic rvalid_reg;

    ////////////////////////////////////////////////////////////////////////
    // pin inputs are synchronous already, so one stage of history is enough
    // RULE_15: edge pulse forming
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            pin_prev_reg <= REG8_RESET;
        end
        else
        begin
            pin_prev_reg <= port_pin_input_i;
        end
    end

    // RULE_15: one-cycle edge pulses
    assign rise_pulse = port_pin_input_i & ~pin_prev_reg;
    assign fall_pulse = ~port_pin_input_i & pin_prev_reg;
    // RULE_03: rising arm
    // RULE_04: falling arm
    // RULE_05: disabled polarity masked
    assign edge_hit = (rise_pulse & rising_edge_enable_reg) | (fall_pulse & falling_edge_enable_reg);

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic wr_take;
    logic rd_take;
    logic addr_ok;

    function automatic logic decode_ok(input logic [ADDR_W-1:0] a);
        decode_ok = (a == RISE_EN_ADDR) || (a == FALL_EN_ADDR) || (a == FLAGS_ADDR)
            || (a == CTRL_ADDR) || (a == SLEEP_ADDR);
    endfunction : decode_ok

    // reads are captured in the idle cycle; writes land only at the edge where waitrequest is low
    assign wr_take = (bus_state_reg == PECINT_ACK) && avm_req_i.write;
    assign rd_take = (bus_state_reg == PECINT_IDLE) && avm_req_i.read;
    assign addr_ok = decode_ok(avm_req_i.address);

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            bus_state_reg <= PECINT_IDLE;
        end
        else
        begin
            unique case (bus_state_reg)
                PECINT_IDLE:
                begin
                    if (avm_req_i.read || avm_req_i.write)
                    begin
                        bus_state_reg <= PECINT_ACK;
                    end
                end
                PECINT_ACK:
                begin
                    bus_state_reg <= PECINT_IDLE;
                end
                default:
                begin
                    bus_state_reg <= PECINT_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable registers
    // RULE_10: enables clear on reset
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rising_edge_enable_reg <= REG8_RESET;
            falling_edge_enable_reg <= REG8_RESET;
            change_irq_master_enable_reg <= 1'b0;
        end
        else if (wr_take && avm_req_i.byteenable[0])
        begin
            if (avm_req_i.address == RISE_EN_ADDR)
            begin
                rising_edge_enable_reg <= avm_req_i.writedata[7:0];
            end
            if (avm_req_i.address == FALL_EN_ADDR)
            begin
                falling_edge_enable_reg <= avm_req_i.writedata[7:0];
            end
            if (avm_req_i.address == CTRL_ADDR)
            begin
                change_irq_master_enable_reg <= avm_req_i.writedata[CTRL_MASTER_EN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags: software write applied first, then hardware set wins
    always_comb
    begin
        pin_change_flags_next = pin_change_flags_reg;
        // RULE_08: software read/write access
        if (wr_take && avm_req_i.byteenable[0] && (avm_req_i.address == FLAGS_ADDR))
        begin
            pin_change_flags_next = avm_req_i.writedata[7:0];
        end
        // RULE_13: edge beats clearing write
        // RULE_06: armed edge sets flag
        pin_change_flags_next = pin_change_flags_next | edge_hit;
    end

    // RULE_10: flags clear on reset
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            pin_change_flags_reg <= REG8_RESET;
        end
        else
        begin
            pin_change_flags_reg <= pin_change_flags_next;
        end
    end

    // RULE_11: summary is OR of flags
    // RULE_09: summary follows the pin flag
    assign change_summary_flag = |pin_change_flags_reg;

    ////////////////////////////////////////////////////////////////////////
    // request and wake come from the stored flags, so a flag is always visible first
    // RULE_16: request is enable AND summary
    // RULE_12: master enable gates request and wake, not the flags
    // RULE_01: wake gated by master enable
    // RULE_02: flag recorded before wake
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= change_irq_master_enable_reg && change_summary_flag;
            wake_reg <= change_irq_master_enable_reg && change_summary_flag && sleep_i;
        end
    end

    assign irq_o = irq_reg;
    assign wake_o = wake_reg;

    ////////////////////////////////////////////////////////////////////////
    // read data
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rdata_reg <= UNMAPPED_READ;
            resp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= rd_take;
            if (rd_take || wr_take)
            begin
                resp_reg <= addr_ok ? RESP_OKAY : RESP_DECODEERROR;
                rdata_reg <= UNMAPPED_READ;
                if (rd_take)
                begin
                    unique case (avm_req_i.address)
                        RISE_EN_ADDR: rdata_reg[7:0] <= rising_edge_enable_reg;
                        FALL_EN_ADDR: rdata_reg[7:0] <= falling_edge_enable_reg;
                        // RULE_07: flag reads zero once cleared
                        FLAGS_ADDR: rdata_reg[7:0] <= pin_change_flags_reg;
                        CTRL_ADDR:
                        begin
                            rdata_reg[CTRL_MASTER_EN_BIT] <= change_irq_master_enable_reg;
                            rdata_reg[CTRL_SUMMARY_BIT] <= change_summary_flag;
                        end
                        SLEEP_ADDR: rdata_reg[0] <= sleep_i;
                        default: rdata_reg <= UNMAPPED_READ;
                    endcase
                end
            end
        end
    end

    always_comb
    begin
        avm_rsp_o.readdata = rdata_reg;
        avm_rsp_o.readdatavalid = rvalid_reg;
        avm_rsp_o.response = resp_reg;
        avm_rsp_o.waitrequest = (avm_req_i.read || avm_req_i.write) && (bus_state_reg != PECINT_ACK);
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    flag_set_edge_a: assert property (@(posedge clk_i) disable iff (srst_i) // RULE_06
        (rise_pulse[0] && rising_edge_enable_reg[0]) |=> pin_change_flags_reg[0])
        else $error("armed rising edge did not set flag 0");

    fall_set_edge_a: assert property (@(posedge clk_i) disable iff (srst_i) // RULE_04
        (fall_pulse[3] && falling_edge_enable_reg[3]) |=> pin_change_flags_reg[3])
        else $error("armed falling edge did not set flag 3");

    disabled_no_set_a: assert property (@(posedge clk_i) disable iff (srst_i) // RULE_05
        (!pin_change_flags_reg[2] && !edge_hit[2]
            && !(wr_take && avm_req_i.address == FLAGS_ADDR)) |=> !pin_change_flags_reg[2])
        else $error("flag 2 set without armed edge or write");

    rise_arm_a: assert property (@(posedge clk_i) disable iff (srst_i) // RULE_03
        ($rose(port_pin_input_i[1]) && rising_edge_enable_reg[1]) |=> pin_change_flags_reg[1])
        else $error("armed rising pin 1 did not set its flag");

    edge_beats_clear_a: assert property (@(posedge clk_i) disable iff (srst_i) // RULE_13
        (edge_hit != 8'h00) |=> ((pin_change_flags_reg & $past(edge_hit)) == $past(edge_hit)))
        else $error("edge lost during clearing write");

    sw_write_flags_a: assert property (@(posedge clk_i) disable iff (srst_i) // RULE_08
        (wr_take && avm_req_i.byteenable[0] && avm_req_i.address == FLAGS_ADDR && edge_hit == 8'h00)
            |=> (pin_change_flags_reg == $past(avm_req_i.writedata[7:0])))
        else $error("software flag write not stored");

    summary_or_a: assert property (@(posedge clk_i) disable iff (srst_i) // RULE_11
        change_summary_flag == (pin_change_flags_reg != 8'h00))
        else $error("summary flag differs from flag OR");

    irq_gate_a: assert property (@(posedge clk_i) disable iff (srst_i) // RULE_16
        ##1 irq_o == $past(change_irq_master_enable_reg && change_summary_flag))
        else $error("irq not enable AND summary one cycle later");

    no_irq_masked_a: assert property (@(posedge clk_i) disable iff (srst_i) // RULE_12
        (!change_irq_master_enable_reg)[*2] |-> !irq_o)
        else $error("irq raised with master enable clear");

    wake_gate_a: assert property (@(posedge clk_i) disable iff (srst_i) // RULE_01
        wake_o |-> ($past(change_irq_master_enable_reg) && $past(sleep_i) && $past(pin_change_flags_reg) != 8'h00))
        else $error("wake without enable, sleep or flag");

    reset_clear_a: assert property (@(posedge clk_i) // RULE_10
        srst_i |=> (pin_change_flags_reg == 8'h00 && rising_edge_enable_reg == 8'h00
            && falling_edge_enable_reg == 8'h00))
        else $error("registers not clear after reset");

    wait_one_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (bus_state_reg == PECINT_IDLE && (avm_req_i.read || avm_req_i.write)) |=> !avm_rsp_o.waitrequest)
        else $error("waitrequest not released in one cycle");

    sleep_wake_c: cover property (@(posedge clk_i) disable iff (srst_i)
        sleep_i && edge_hit != 8'h00 ##2 wake_o);
    clear_race_c: cover property (@(posedge clk_i) disable iff (srst_i)
        wr_take && avm_req_i.address == FLAGS_ADDR && edge_hit != 8'h00);
    both_edges_c: cover property (@(posedge clk_i) disable iff (srst_i)
        rising_edge_enable_reg[5] && falling_edge_enable_reg[5] && fall_pulse[5]);

endmodule : pecint_top

// File: verif/pecint_pin_model.sv
// far-side pin driver for the pin edge change interrupt bench
`timescale 1ns/1ps

module pecint_pin_model
#(
    parameter int PINS = 8
)(
    input wire logic clk_i, // system clock
    output logic [PINS-1:0] pins_o // port pin levels
);
    initial pins_o = '0;

    // prompt far side: a new level lands right after a clock edge
    task automatic drive(input logic [PINS-1:0] v);
        pins_o <= v;
    endtask : drive

    // slow far side: toggle some pins, hold them, then toggle back
    task automatic pulse(input logic [PINS-1:0] v, input int hold);
        pins_o <= pins_o ^ v;
        repeat (hold) @(posedge clk_i);
        pins_o <= pins_o ^ v;
    endtask : pulse
endmodule : pecint_pin_model

// File: verif/pecint_tb.sv
// self-checking bench for the pin edge change interrupt unit
`timescale 1ns/1ps

module pecint_tb;
    import pecint_pkg::*;

    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic sleep_i = 1'b0;
    logic [PIN_COUNT-1:0] pins;
    pecint_avm_req_t req = '0;
    pecint_avm_rsp_t rsp;
    logic irq_o;
    logic wake_o;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;

    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    pecint_top DUT (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .port_pin_input_i(pins),
        .sleep_i(sleep_i),
        .avm_req_i(req),
        .avm_rsp_o(rsp),
        .irq_o(irq_o),
        .wake_o(wake_o)
    );

    pecint_pin_model u_pins (
        .clk_i(clk_i),
        .pins_o(pins)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one bus transfer, entered just after a rising edge; the slave decides the wait
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] be);
        req.address <= a;
        req.read <= ~wr;
        req.write <= wr;
        // upper lanes carry the byte too; the slave must ignore them and read them back as 0
        req.writedata <= {d, d, d, d};
        req.byteenable <= be;
        do
            @(posedge clk_i);
        while (rsp.waitrequest !== 1'b0);
        rdata = rsp.readdata;
        rresp = rsp.response;
        req.read <= 1'b0;
        req.write <= 1'b0;
        // a gap edge keeps the strobe from being driven twice in one step
        @(posedge clk_i);
    endtask : xfer

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask : wr

    task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 8'h00, 4'h1);
        check(what, rdata, exp);
    endtask : rdchk

    // outputs are looked at mid-cycle, where they have settled
    task automatic outs(input int n, input logic ei, input logic ew);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
        check("irq_o", {31'h0, irq_o}, {31'h0, ei});
        check("wake_o", {31'h0, wake_o}, {31'h0, ew});
        @(posedge clk_i);
    endtask : outs

    task automatic done(input string name);
        $display("test %s done", name);
    endtask : done

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_fail++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        rdchk("rise_en", RISE_EN_ADDR, 32'h0);
        rdchk("fall_en", FALL_EN_ADDR, 32'h0);
        rdchk("flags", FLAGS_ADDR, 32'h0);
        rdchk("ctrl", CTRL_ADDR, 32'h0);
        wr(4'h7, 8'hFF);
        rdchk("unmapped", 4'h7, 32'h0);
        check("unmapped resp", {30'h0, rresp}, {30'h0, RESP_DECODEERROR});
        done("reset");
        wr(RISE_EN_ADDR, 8'h01);
        u_pins.drive(8'h01);
        outs(3, 1'b0, 1'b0);
        rdchk("rise flag", FLAGS_ADDR, 32'h01);
        rdchk("summary", CTRL_ADDR, 32'h01);
        // clear while the pin stays high: a held level must not set it again
        wr(FLAGS_ADDR, 8'h00);
        u_pins.drive(8'h00);
        outs(3, 1'b0, 1'b0);
        rdchk("unarmed fall", FLAGS_ADDR, 32'h0);
        done("rising");
        wr(RISE_EN_ADDR, 8'h80);
        wr(FALL_EN_ADDR, 8'h80);
        u_pins.drive(8'h80);
        outs(3, 1'b0, 1'b0);
        rdchk("both rise", FLAGS_ADDR, 32'h80);
        wr(FLAGS_ADDR, 8'h00);
        u_pins.drive(8'h00);
        outs(3, 1'b0, 1'b0);
        rdchk("both fall", FLAGS_ADDR, 32'h80);
        u_pins.pulse(8'h08, 5);
        outs(3, 1'b0, 1'b0);
        rdchk("unarmed pin", FLAGS_ADDR, 32'h80);
        done("both edges");
        sleep_i <= 1'b1;
        wr(CTRL_ADDR, 8'h08);
        outs(2, 1'b1, 1'b1);
        rdchk("sleep stat", SLEEP_ADDR, 32'h1);
        rdchk("ctrl on", CTRL_ADDR, 32'h09);
        wr(FLAGS_ADDR, 8'h00);
        outs(2, 1'b0, 1'b0);
        u_pins.drive(8'h80);
        for (int i = 0; i < 8 && wake_o !== 1'b1; i++)
            @(negedge clk_i);
        check("wake edge", {31'h0, wake_o}, 32'h1);
        @(posedge clk_i);
        rdchk("sleep flag", FLAGS_ADDR, 32'h80);
        wr(CTRL_ADDR, 8'h00);
        outs(2, 1'b0, 1'b0);
        sleep_i <= 1'b0;
        done("sleep");
        wr(FLAGS_ADDR, 8'hA4);
        rdchk("sw set", FLAGS_ADDR, 32'hA4);
        // clear only the bits seen set, keeping the rest as read
        wr(FLAGS_ADDR, 8'hA4 & ~8'h24);
        rdchk("masked clear", FLAGS_ADDR, 32'h80);
        wr(RISE_EN_ADDR, 8'h81);
        // the pin rises so that its edge meets the edge at which the clearing write lands
        fork
            wr(FLAGS_ADDR, 8'h00);
            begin
                @(posedge clk_i);
                u_pins.drive(8'h81);
            end
        join
        rdchk("edge in clear", FLAGS_ADDR, 32'h01);
        xfer(1'b1, RISE_EN_ADDR, 8'h00, 4'h0);
        rdchk("lane off", RISE_EN_ADDR, 32'h81);
        done("flags");
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        rdchk("rst rise", RISE_EN_ADDR, 32'h0);
        rdchk("rst fall", FALL_EN_ADDR, 32'h0);
        rdchk("rst flags", FLAGS_ADDR, 32'h0);
        outs(1, 1'b0, 1'b0);
        done("second reset");
        stop_test();
    end
endmodule : pecint_tb
